// ### hdl/hhb_spi_ctrl.sv
// Serial command and status port with driver and fault logic of the hex half-bridge.
// Assumes sclk from the host; fault detectors arrive asynchronously on mclk side.
`timescale 1ns/10ps
module hhb_spi_ctrl
   import hhb_pkg::*;
(
   // System clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   // Serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEn_n,
   // Fault detector inputs
   input hhb_fault_type faultIn,
   // Driver outputs and command strobe
   output logic [DRV_NUM-1:0] driverOn,
   output logic cmdStrobe
);

   // ----------------------------------------
   // Link domain on sclk
   // ----------------------------------------
   // Status is captured by mclk and held stable; sclk side reads it at select.
   logic [WORD_BITS-1:0] shIn_ff, nxt_shIn;
   logic [WORD_BITS-1:0] shOut_ff, nxt_shOut;
   logic [CNT_BITS-1:0] cnt_ff, nxt_cnt;
   logic started_ff, nxt_started;
   logic [WORD_BITS-1:0] frameWord_ff, nxt_frameWord;
   logic frameOk_ff, nxt_frameOk;
   hhb_status_type statusHold_ff;

   always_comb begin
      nxt_shIn = shIn_ff;
      nxt_cnt = cnt_ff;
      nxt_started = started_ff;
      if (chip_select_n) begin
         nxt_cnt = CNT_ZERO;
         nxt_started = 1'b0;
      end else begin
         nxt_shIn = {serialIn, shIn_ff[WORD_BITS-1:1]};
         nxt_cnt = cnt_ff + CNT_ONE;
         nxt_started = 1'b1;
      end
   end

   // A high select clears the count at once, so no sclk edge is needed between frames.
   always_ff @(negedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         cnt_ff <= CNT_ZERO;
         started_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         started_ff <= nxt_started;
      end
   end

   always_ff @(negedge sclk) begin
      shIn_ff <= nxt_shIn;
   end

   // rising shift, status out, capture at select.
   always_comb begin
      // Bits from the upstream device follow our own word through the chain.
      nxt_shOut = {shIn_ff[WORD_BITS-1], shOut_ff[WORD_BITS-1:1]};
      // The rising edge before the first falling one loads the frozen status word.
      if (!started_ff) begin
         nxt_shOut = statusHold_ff;
      end
   end

   always_ff @(posedge sclk) begin
      shOut_ff <= nxt_shOut;
   end

   // load on select rise, frame check.
   always_comb begin
      nxt_frameWord = shIn_ff;
      nxt_frameOk = started_ff && (cnt_ff == CNT_ZERO);
   end

   always_ff @(posedge chip_select_n) begin
      frameWord_ff <= nxt_frameWord;
      frameOk_ff <= nxt_frameOk;
   end

   assign serialOutEn_n = chip_select_n;
   // Until the first falling edge the captured word shows its first bit directly.
   assign serialOut = started_ff ? shOut_ff[0] : statusHold_ff[0];

   // ----------------------------------------
   // Crossings into mclk
   // ----------------------------------------
   // Three stages; a change counts once the second and third agree.
   logic [2:0] csSync_ff, nxt_csSync;
   logic [2:0] enSync_ff, nxt_enSync;
   logic csSeen_ff, nxt_csSeen;
   logic awake_ff, nxt_awake;
   hhb_fault_type faultS1_ff, faultS2_ff, faultS3_ff;
   hhb_fault_type faultHeld_ff, nxt_faultHeld;

   // A level is taken only when both late stages show it, so a slow settle never glitches.
   function automatic logic settle_bit(input logic late, input logic last, input logic held);
      return (late & last) | (held & (late | last));
   endfunction

   function automatic hhb_fault_type settle_fault(input hhb_fault_type late,
      input hhb_fault_type last, input hhb_fault_type held);
      return hhb_fault_type'((late & last) | (held & (late | last)));
   endfunction

   always_comb begin
      nxt_csSync = {csSync_ff[1:0], chip_select_n};
      nxt_enSync = {enSync_ff[1:0], enable};
      nxt_csSeen = settle_bit(csSync_ff[1], csSync_ff[2], csSeen_ff);
      nxt_awake = settle_bit(enSync_ff[1], enSync_ff[2], awake_ff);
      nxt_faultHeld = settle_fault(faultS2_ff, faultS3_ff, faultHeld_ff);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         csSync_ff <= '1;
         enSync_ff <= SYNC_ZERO;
         csSeen_ff <= 1'b1;
         awake_ff <= 1'b0;
         faultHeld_ff <= '0;
      end else begin
         csSync_ff <= nxt_csSync;
         enSync_ff <= nxt_enSync;
         csSeen_ff <= nxt_csSeen;
         awake_ff <= nxt_awake;
         faultHeld_ff <= nxt_faultHeld;
      end
      faultS1_ff <= faultIn;
      faultS2_ff <= faultS1_ff;
      faultS3_ff <= faultS2_ff;
   end

   // The frame word was loaded at the select edge, so it is stable long before this event.
   logic frameEvt, awake, csHigh;
   assign frameEvt = csSync_ff[2] & csSync_ff[1] & ~csSeen_ff;
   assign awake = awake_ff;
   assign csHigh = csSync_ff[2] & csSync_ff[1];

   hhb_fault_type fault;
   assign fault = faultHeld_ff;

   // ----------------------------------------
   // Control and fault state on mclk
   // ----------------------------------------
   hhb_cmd_type cmd_ff, nxt_cmd;
   logic [DRV_NUM-1:0] latchOff_ff, nxt_latchOff;
   logic psf_ff, nxt_psf, uld_ff, nxt_uld, old_ff, nxt_old;
   logic [DRV_NUM-1:0] nxt_driverOn;
   hhb_status_type nxt_statusHold;
   logic nxt_cmdStrobe;
   hhb_cmd_type newCmd;
   logic accept;

   always_comb begin
      newCmd = hhb_cmd_type'(frameWord_ff);
      accept = frameEvt && frameOk_ff && awake;
      nxt_cmd = cmd_ff;
      nxt_latchOff = latchOff_ff;
      nxt_psf = psf_ff;
      nxt_uld = uld_ff;
      nxt_old = old_ff;
      if (accept) begin
         nxt_cmd = newCmd;
         if (newCmd.clrReq) begin
            nxt_psf = 1'b0;
            nxt_uld = 1'b0;
            nxt_old = 1'b0;
            // latch off released by a clear.
            nxt_latchOff = '0;
         end
      end
      // Set wins over a clear arriving together.
      // supply fail.
      if (fault.overvoltage || fault.undervoltage) begin
         nxt_psf = 1'b1;
      end
      if (|(fault.underload & cmd_ff.drv)) begin
         nxt_uld = 1'b1;
      end
      if (|fault.overcurrent) begin
         nxt_old = 1'b1;
      end
      if (cmd_ff.ocdEn) begin
         nxt_latchOff = nxt_latchOff | fault.overcurrent;
      end
      if (cmd_ff.uldEn) begin
         nxt_latchOff = nxt_latchOff | (fault.underload & cmd_ff.drv);
      end
      if (!awake) begin
         nxt_cmd = CMD_RESET;
         nxt_latchOff = '0;
         nxt_psf = 1'b0;
         nxt_uld = 1'b0;
         nxt_old = 1'b0;
      end
      // Undervoltage always keeps drivers off; commands stay stored.
      // overvoltage off, restored after.
      nxt_driverOn = cmd_ff.drv & ~latchOff_ff;
      if (fault.undervoltage || (cmd_ff.ovloEn && fault.overvoltage)) begin
         nxt_driverOn = '0;
      end
      // driver states, thermal warning, captured only while idle.
      nxt_statusHold = statusHold_ff;
      if (csHigh) begin
         nxt_statusHold = '{supplyFail: psf_ff, underload: uld_ff, overload: old_ff,
                            drv: driverOn, thermalWarn: fault.thermalWarn};
      end
      nxt_cmdStrobe = accept;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_ff <= CMD_RESET;
         latchOff_ff <= '0;
         psf_ff <= 1'b0;
         uld_ff <= 1'b0;
         old_ff <= 1'b0;
         driverOn <= '0;
         statusHold_ff <= '0;
         cmdStrobe <= 1'b0;
      end else begin
         cmd_ff <= nxt_cmd;
         latchOff_ff <= nxt_latchOff;
         psf_ff <= nxt_psf;
         uld_ff <= nxt_uld;
         old_ff <= nxt_old;
         driverOn <= nxt_driverOn;
         statusHold_ff <= nxt_statusHold;
         cmdStrobe <= nxt_cmdStrobe;
      end
   end

endmodule

// ### pkg/hhb_pkg.sv
// Constants and carrier types for the hex half-bridge serial control port.
// Assumes a system clock mclk and a free serial clock from an external host.
package hhb_pkg;
   localparam int WORD_BITS = 16;
   localparam int CNT_BITS = 4;
   localparam int BIT_OVERVOLTAGE_SHUTDOWN_ENABLE = 15;
   localparam int BIT_ULD = 14;
   localparam int BIT_OCD = 13;
   localparam int BIT_CLR = 0;
   localparam int DRV_LSB = 1;
   localparam int DRV_NUM = 12;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [CNT_BITS-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;
   localparam logic [2:0] SYNC_ZERO = 3'h0;
   localparam int IDLE_MIN_NS = 200;
   localparam int MCLK_NS = 8;
   localparam int IDLE_MIN_CYC = (IDLE_MIN_NS + MCLK_NS - 1) / MCLK_NS;

   typedef struct packed {
      logic ovloEn;
      logic uldEn;
      logic ocdEn;
      logic [DRV_NUM-1:0] drv;
      logic clrReq;
   } hhb_cmd_type;

   typedef struct packed {
      logic supplyFail;
      logic underload;
      logic overload;
      logic [DRV_NUM-1:0] drv;
      logic thermalWarn;
   } hhb_status_type;

   typedef struct packed {
      logic overvoltage;
      logic undervoltage;
      logic thermalWarn;
      logic [DRV_NUM-1:0] overcurrent;
      logic [DRV_NUM-1:0] underload;
   } hhb_fault_type;
endpackage

// ### verif/hhb_host_model.sv
// Serial bus master model that clocks frames into the port.
// Assumes the bench calls xfer and nothing else drives these lines.
`timescale 1ns/10ps
module hhb_host_model (
   // Serial lines
   output logic sclk,
   output logic chip_select_n,
   output logic serialIn,
   input wire logic serialOut
);
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      serialIn = 1'b0;
   end
   task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
      rx = '0;
      chip_select_n = 1'b0;
      #100;
      for (int i = 0; i < nBits; i++) begin
         serialIn = tx[i];
         sclk = 1'b1;
         #62.5;
         rx[i] = serialOut;
         sclk = 1'b0;
         #62.5;
      end
      chip_select_n = 1'b1;
      // The input has a pull-down, so a released line reads low.
      serialIn = 1'b0;
      #250;
   endtask
endmodule

// ### verif/hhb_spi_checker.sv
// Pin-level assertions for the hex half-bridge serial port.
// Assumes it is bound to hhb_spi_ctrl and samples on mclk.
`timescale 1ns/10ps
module hhb_spi_checker
   import hhb_pkg::*;
(
   // Clock, reset and pins
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic serialOut,
   input wire logic serialOutEn_n,
   input hhb_fault_type faultIn,
   input wire logic [DRV_NUM-1:0] driverOn,
   input wire logic cmdStrobe
);
   logic [3:0] quietCnt_ff;
   logic [3:0] nxt_quietCnt;
   // Quiet time lets fault and enable synchronisers settle first.
   always_comb begin
      nxt_quietCnt = quietCnt_ff;
      if (faultIn != '0 || !enable) nxt_quietCnt = 4'h0;
      else if (quietCnt_ff != 4'h8) nxt_quietCnt = quietCnt_ff + 4'h1;
   end
   always_ff @(posedge mclk) quietCnt_ff <= rst ? 4'h0 : nxt_quietCnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence uvHeld;
      faultIn.undervoltage [*8];
   endsequence
   sequence sleepHeld;
      !enable [*8];
   endsequence
   // ----
   // Assertions
   // ----
   chk_oe_follows_cs: assert property (serialOutEn_n == chip_select_n)
      else $error("output enable differs from select");
   chk_strobe_single: assert property (cmdStrobe |=> !cmdStrobe)
      else $error("strobe longer than one cycle");
   chk_strobe_after_cs: assert property (cmdStrobe |-> chip_select_n && $past(chip_select_n, 2))
      else $error("strobe without a closed frame");
   chk_reset_clears: assert property (disable iff (1'b0) rst |=> driverOn == '0 && !cmdStrobe)
      else $error("reset left drivers on");
   chk_sleep_clears: assert property (sleepHeld |-> driverOn == '0)
      else $error("drivers on while asleep");
   chk_uv_forces_off: assert property (uvHeld |-> driverOn == '0)
      else $error("drivers on during undervoltage");
   chk_drv_hold: assert property (quietCnt_ff == 4'h8 && !cmdStrobe && !$past(cmdStrobe)
      && !$past(cmdStrobe, 2) |=> $stable(driverOn))
      else $error("drivers changed without command");
   chk_so_rise_only: assert property (!chip_select_n && !$past(chip_select_n, 8)
      && sclk == $past(sclk) |-> $stable(serialOut))
      else $error("serial output moved off the rising edge");
endmodule
bind hhb_spi_ctrl hhb_spi_checker chk (.mclk, .rst, .enable, .sclk, .chip_select_n, .serialOut,
   .serialOutEn_n, .faultIn, .driverOn, .cmdStrobe);

// ### verif/tb_hhb_spi_ctrl.sv
// Self-checking bench for the hex half-bridge serial port.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/10ps
module tb_hhb_spi_ctrl
   import hhb_pkg::*;
;
   logic mclk, rst, enable, sclk, chip_select_n, serialIn, serialOut, serialOutEn_n, cmdStrobe;
   hhb_fault_type faultIn;
   logic [DRV_NUM-1:0] driverOn, prevDrv;
   logic [31:0] rx, seed;
   int errors, checks;
   int strobes = 0;
   hhb_spi_ctrl uut (.mclk, .rst, .enable, .sclk, .chip_select_n, .serialIn, .serialOut,
      .serialOutEn_n, .faultIn, .driverOn, .cmdStrobe);
   hhb_host_model host (.sclk, .chip_select_n, .serialIn, .serialOut);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) strobes <= strobes + (cmdStrobe === 1'b1 ? 1 : 0);
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] status_word(input logic [2:0] flags, input logic [11:0] drv,
      input logic tw);
      return {16'h0, flags, drv, tw};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic send(input logic [31:0] tx, input int n, input logic acc);
      int s0;
      @(negedge mclk);
      s0 = strobes;
      host.xfer(tx, n, rx);
      check("strobe", strobes - s0, {31'h0, acc});
   endtask
   task automatic pulse(input logic [26:0] f, input logic [11:0] expDrv);
      @(negedge mclk);
      faultIn = hhb_fault_type'(f);
      repeat (10) @(negedge mclk);
      check("fault drivers", driverOn, expDrv);
      faultIn = '0;
      repeat (10) @(negedge mclk);
   endtask
   initial begin
      #300000;
      errors++;
      wrap_up();
   end
   initial begin
      seed = 32'h37494940;
      rst = 1'b1;
      enable = 1'b1;
      faultIn = '0;
      errors = 0;
      checks = 0;
      prevDrv = '0;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (10) @(negedge mclk);
      for (int k = 0; k < 8; k++) begin
         seed = xorshift(seed);
         send({16'h0, seed[15:1], 1'b0}, 16, 1'b1);
         check("status", rx, status_word(3'h0, prevDrv, 1'b0));
         check("drivers", driverOn, seed[12:1]);
         prevDrv = seed[12:1];
      end
      send(32'h1FFFE, 15, 1'b0);
      send(32'h1FFFE, 17, 1'b0);
      check("kept", driverOn, prevDrv);
      send(32'hFFFE1234, 32, 1'b1);
      check("chain", rx, {16'h1234, 3'h0, prevDrv, 1'b0});
      check("chain drivers", driverOn, 12'hFFF);
      pulse(27'h4000000, 12'h000);
      check("ov back", driverOn, 12'hFFF);
      pulse(27'h0002000, 12'hFFD);
      pulse(27'h0000004, 12'hFF9);
      pulse(27'h2000000, 12'h000);
      faultIn = hhb_fault_type'(27'h1000000);
      repeat (10) @(negedge mclk);
      send(32'hFFFF, 16, 1'b1);
      check("flags", rx, status_word(3'h7, 12'hFF9, 1'b1));
      @(negedge mclk);
      faultIn = '0;
      repeat (10) @(negedge mclk);
      send(32'hFFFE, 16, 1'b1);
      check("cleared", {rx[15:13], rx[0]}, 32'h0);
      @(negedge mclk);
      enable = 1'b0;
      repeat (10) @(negedge mclk);
      check("sleep", driverOn, 12'h000);
      enable = 1'b1;
      repeat (10) @(negedge mclk);
      send(32'h0, 16, 1'b1);
      check("wake", rx[12:1], 32'h0);
      wrap_up();
   end
endmodule
